// >>> ccpo_channel.sv
// compare and standard pwm output channel
`timescale 1ns/1ps
`include "ccpo_consts.svh"

// Functional notes
// - compare valid only with synchronous timebase
// - every mode sets event flag; match triggers conversion
// - removed match cancels pending timebase clear
// - sleep compare needs running timebase; wakes
// - pwm waveform up to ten bits
// - period match: set pin unless new duty is zero, load duty buffer
// - period is (limit+1)*4*tosc*prescale
// - postscaler never affects pwm period
// - duty writes take effect at period match
// - time base is counter plus two bits
// - time base equals duty: pin low
// - pulse width equals duty times tosc prescale
// - resolution log2 of 4*(limit+1)
// - duty beyond period leaves pin unchanged
// - sleep freezes pwm pin and duty buffer; compare runs on with timebase
// - align bit places duty bits
// - right or left aligned duty layout
// - mode field decoding
// - compare stored value against timebase
// - reset clears channel, pin to input
module ccpo_channel (
    input wire logic clk_sys,
    input wire logic rst,
    input ccpo_pkg::ccpo_ctrl_t ctrl,
    input wire logic [15:0] duty_compare_value,
    input wire logic [15:0] compare_timebase,
    input ccpo_pkg::ccpo_timer_t period_timer,
    input wire logic conv_source_sel,
    input wire logic event_irq_en,
    input wire logic sleep_mode,
    input wire logic timebase_running,
    input wire logic pin_direction_bit,
    input wire logic event_flag_clear,
    output ccpo_pkg::ccpo_status_t status
);
    import ccpo_pkg::*;

    typedef enum logic [1:0] {ST_OFF, ST_COMPARE, ST_PWM} ccpo_state_t;

    ccpo_state_t state_q;
    logic pin_q;
    logic flag_q;
    logic trig_q;
    logic clr_q;
    logic wake_q;
    logic oe_q;
    logic pulse_q;
    logic clr_pend_q;
    logic match_prev_q;
    logic [9:0] duty_buf_q;

    // align selection picks ten duty bits out of the register pair
    function automatic logic [9:0] duty_extract(input logic left, input logic [15:0] v);
        duty_extract = left ? {v[15:8], v[7:6]} : {v[9:8], v[7:0]};
    endfunction

    wire logic is_pwm = ctrl.enable && (ctrl.mode[3:2] == `CCPO_PWM_MSB2);
    wire logic is_cmp_mode = (ctrl.mode[3:2] == `CCPO_CMP_MSB2) || (ctrl.mode == `CCPO_MODE_TOG)
        || (ctrl.mode == `CCPO_MODE_TOG_CLR);
    // capture codes share the mode field but are not served by this output channel
    wire logic is_cmp = ctrl.enable && is_cmp_mode;
    // running clock stops in sleep unless the timebase keeps its own clock
    wire logic cmp_run = is_cmp && (!sleep_mode || timebase_running);
    wire logic pwm_run = is_pwm && !sleep_mode;
    wire logic cmp_eq = duty_compare_value == compare_timebase;
    wire logic cmp_hit = cmp_run && cmp_eq && !match_prev_q;
    wire logic mode_clr = ctrl.mode == `CCPO_MODE_TOG_CLR || ctrl.mode == `CCPO_MODE_PULSE_CLR;
    wire logic [9:0] duty_new = duty_extract(ctrl.align_left, duty_compare_value);
    // counter extended with phase bits; phase source chosen by the timer block
    wire logic [9:0] time_base = {period_timer.count, period_timer.phase_bits};
    wire logic pwm_match = pwm_run && period_timer.period_match;
    wire logic duty_off = pwm_run && !pwm_match && (time_base == duty_buf_q);
    wire logic pwm_evt = pwm_match;
    wire logic evt = cmp_hit || pwm_evt;

    logic cmp_pin_d;
    always_comb
    begin
        cmp_pin_d = pin_q;
        case (ctrl.mode)
            `CCPO_MODE_TOG, `CCPO_MODE_TOG_CLR: cmp_pin_d = ~pin_q;
            `CCPO_MODE_SET: cmp_pin_d = 1'b1;
            `CCPO_MODE_CLR: cmp_pin_d = 1'b0;
            `CCPO_MODE_PULSE, `CCPO_MODE_PULSE_CLR: cmp_pin_d = 1'b1;
            default: cmp_pin_d = pin_q;
        endcase
    end

    ccpo_state_t state_d;
    assign state_d = is_pwm ? ST_PWM : (is_cmp ? ST_COMPARE : ST_OFF);

    logic pin_d;
    always_comb
    begin
        pin_d = pin_q;
        // next state, so a period match on the first pwm edge already sets the pin
        case (state_d)
            ST_COMPARE:
            begin
                if (cmp_hit)
                    pin_d = cmp_pin_d;
                else if (pulse_q)
                    pin_d = 1'b0;
            end
            ST_PWM:
            begin
                // a duty beyond the period never matches, so the level simply holds
                if (pwm_match)
                    pin_d = (duty_new != `CCPO_DUTY_ZERO);
                else if (duty_off)
                    pin_d = 1'b0;
            end
            default: pin_d = 1'b0;
        endcase
    end

    wire logic pin_out_d = (state_d == ST_OFF) ? 1'b0 : pin_d;
    wire logic oe_d = !pin_direction_bit && (state_d != ST_OFF);
    // set wins over a coincident software clear
    wire logic flag_d = evt || (flag_q && !event_flag_clear);
    wire logic trig_d = cmp_hit && conv_source_sel;
    wire logic pulse_d = cmp_hit && ctrl.mode[3] && ctrl.mode[1];
    // clear waits one edge and is dropped if the match has gone
    wire logic clr_pend_d = cmp_hit && mode_clr;
    wire logic clr_d = clr_pend_q && cmp_eq && is_cmp;
    wire logic wake_d = sleep_mode && cmp_hit && event_irq_en;
    wire logic match_prev_d = cmp_run ? cmp_eq : match_prev_q;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_q <= ST_OFF;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pin_q <= 1'b0;
        else
            pin_q <= pin_out_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            oe_q <= 1'b0;
        else
            oe_q <= oe_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            trig_q <= 1'b0;
        else
            trig_q <= trig_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            clr_q <= 1'b0;
        else
            clr_q <= clr_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            wake_q <= 1'b0;
        else
            wake_q <= wake_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pulse_q <= 1'b0;
        else
            pulse_q <= pulse_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            clr_pend_q <= 1'b0;
        else
            clr_pend_q <= clr_pend_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            match_prev_q <= 1'b0;
        else
            match_prev_q <= match_prev_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            duty_buf_q <= `CCPO_DUTY_ZERO;
        else if (pwm_match)
            duty_buf_q <= duty_new;
    end

    assign status.pin_level = pin_q;
    assign status.pin_oe = oe_q;
    assign status.event_flag = flag_q;
    assign status.conv_trigger = trig_q;
    assign status.timebase_clear = clr_q;
    assign status.wake_req = wake_q;

    sequence s_cmp_hit_trig;
        cmp_hit && conv_source_sel;
    endsequence

    sequence s_clr_hit;
        cmp_hit && mode_clr;
    endsequence

    sequence s_clr_kept;
        clr_pend_q && cmp_eq && is_cmp;
    endsequence

    sequence s_pulse_start;
        cmp_hit && ctrl.mode[3] && ctrl.mode[1];
    endsequence

    a_conv_trigger: assert property (@(posedge clk_sys) disable iff (rst)
        s_cmp_hit_trig |=> status.conv_trigger)
        else $error("conversion trigger missing after compare match");

    a_event_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
        evt |=> status.event_flag)
        else $error("event flag not set");

    a_clear_cancel: assert property (@(posedge clk_sys) disable iff (rst)
        (clr_pend_q && !cmp_eq) |=> !status.timebase_clear)
        else $error("timebase clear issued after match removed");

    a_period_load: assert property (@(posedge clk_sys) disable iff (rst)
        pwm_match |=> (duty_buf_q == $past(duty_new))
            && (pin_q == ($past(duty_new) != `CCPO_DUTY_ZERO)))
        else $error("period match did not reload duty or set pin");

    a_duty_low: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == ST_PWM && is_pwm && duty_off) |=> !pin_q)
        else $error("pin not cleared at duty match");

    a_sleep_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == ST_PWM && is_pwm && sleep_mode) |=> $stable(pin_q) && $stable(duty_buf_q))
        else $error("pwm state changed during sleep");

    a_duty_stable: assert property (@(posedge clk_sys) disable iff (rst)
        !pwm_match |=> $stable(duty_buf_q))
        else $error("duty buffer changed outside period match");

    a_set_mode: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == ST_COMPARE && cmp_hit && ctrl.mode == `CCPO_MODE_SET && is_cmp) |=> pin_q)
        else $error("set mode did not raise pin");

    a_wake_req: assert property (@(posedge clk_sys) disable iff (rst)
        (sleep_mode && cmp_hit && event_irq_en) |=> status.wake_req)
        else $error("no wake request on compare in sleep");

    a_reset_pin: assert property (@(posedge clk_sys)
        rst |=> !status.pin_oe && !status.pin_level)
        else $error("pin not released by reset");

    a_clear_issue: assert property (@(posedge clk_sys) disable iff (rst)
        (s_clr_hit ##1 s_clr_kept) |=> status.timebase_clear)
        else $error("timebase clear missing after held match");

    a_clear_only_mode: assert property (@(posedge clk_sys) disable iff (rst)
        !clr_pend_q |=> !status.timebase_clear)
        else $error("timebase clear without a pending clear");

    a_trig_single: assert property (@(posedge clk_sys) disable iff (rst)
        status.conv_trigger |=> !status.conv_trigger)
        else $error("conversion trigger longer than one cycle");

    a_trig_unsel: assert property (@(posedge clk_sys) disable iff (rst)
        !conv_source_sel |=> !status.conv_trigger)
        else $error("conversion trigger while not selected");

    a_pulse_high: assert property (@(posedge clk_sys) disable iff (rst)
        s_pulse_start |=> status.pin_level)
        else $error("pulse mode did not raise pin");

    a_pulse_low: assert property (@(posedge clk_sys) disable iff (rst)
        (pulse_q && state_d == ST_COMPARE && !cmp_hit) |=> !status.pin_level)
        else $error("pulse did not end after one cycle");

    a_clear_mode: assert property (@(posedge clk_sys) disable iff (rst)
        (cmp_hit && ctrl.mode == `CCPO_MODE_CLR) |=> !status.pin_level)
        else $error("clear mode did not drop pin");

    a_toggle_mode: assert property (@(posedge clk_sys) disable iff (rst)
        (cmp_hit && (ctrl.mode == `CCPO_MODE_TOG || ctrl.mode == `CCPO_MODE_TOG_CLR))
            |=> status.pin_level != $past(status.pin_level))
        else $error("toggle mode did not invert pin");

    a_off_low: assert property (@(posedge clk_sys) disable iff (rst)
        (state_d == ST_OFF) |=> !status.pin_level && !status.pin_oe)
        else $error("disabled channel still drives pin");

    a_driver_off: assert property (@(posedge clk_sys) disable iff (rst)
        pin_direction_bit |=> !status.pin_oe)
        else $error("pin driven while direction is input");

    a_sleep_no_cmp: assert property (@(posedge clk_sys) disable iff (rst)
        (sleep_mode && !timebase_running) |=> !status.conv_trigger && !status.wake_req)
        else $error("compare acted in sleep without timebase");

    a_flag_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (status.event_flag && !event_flag_clear) |=> status.event_flag)
        else $error("event flag lost without clear");

    a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (event_flag_clear && !evt) |=> !status.event_flag)
        else $error("event flag not cleared");

    a_zero_duty: assert property (@(posedge clk_sys) disable iff (rst)
        (pwm_match && duty_new == `CCPO_DUTY_ZERO) |=> !status.pin_level)
        else $error("zero duty still raised pin");

    a_wrap_sets: assert property (@(posedge clk_sys) disable iff (rst)
        (pwm_match && duty_new != `CCPO_DUTY_ZERO) |=> status.pin_level)
        else $error("period match did not raise pin");

    a_match_rearm: assert property (@(posedge clk_sys) disable iff (rst)
        cmp_hit |=> !cmp_hit)
        else $error("held match hit twice");

    a_wake_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        !sleep_mode |=> !status.wake_req)
        else $error("wake request while awake");
endmodule

// >>> ccpo_consts.svh
// timing, encoding and reset constants for the compare/pwm output channel
`ifndef CCPO_CONSTS_SVH
`define CCPO_CONSTS_SVH
`define CCPO_MODE_OFF 4'h0
`define CCPO_MODE_TOG_CLR 4'h1
`define CCPO_MODE_TOG 4'h2
`define CCPO_MODE_SET 4'h8
`define CCPO_MODE_CLR 4'h9
`define CCPO_MODE_PULSE 4'hA
`define CCPO_MODE_PULSE_CLR 4'hB
`define CCPO_PWM_MSB2 2'h3
`define CCPO_CMP_MSB2 2'h2
`define CCPO_DUTY_ZERO 10'h000
`define CCPO_PS_ONE 2'h0
`define CCPO_PULSE_CYC 1
`endif

// >>> ccpo_load.sv
// load on the channel pin, as seen by the bench
`timescale 1ns/1ps
module ccpo_load (
    input wire logic pin_level,
    input wire logic pin_oe,
    output logic pin_seen
);
    // pull-down holds a released pin low, so stale levels never leak
    assign pin_seen = pin_oe ? pin_level : 1'b0;
endmodule

// >>> ccpo_pkg.sv
// types shared by the compare/pwm output channel
package ccpo_pkg;
    typedef struct packed {
        logic enable;
        logic align_left;
        logic [3:0] mode;
    } ccpo_ctrl_t;

    typedef struct packed {
        logic period_match;
        logic [1:0] phase_bits;
        logic [7:0] count;
    } ccpo_timer_t;

    typedef struct packed {
        logic pin_level;
        logic pin_oe;
        logic event_flag;
        logic conv_trigger;
        logic timebase_clear;
        logic wake_req;
    } ccpo_status_t;
endpackage

// >>> test_ccp_compare_pwm_output.sv
// self-checking bench for the compare/pwm output channel
`timescale 1ns/1ps
module test_ccp_compare_pwm_output;
import ccpo_pkg::*;
logic clk_sys, rst, conv_source_sel, event_irq_en, sleep_mode, timebase_running;
logic pin_direction_bit, event_flag_clear, pin_seen;
logic [15:0] dcv, ctb;
logic [9:0] d10;
ccpo_ctrl_t ctrl;
ccpo_timer_t tmr;
ccpo_status_t status;
int mismatches, tests_run, tb, lim, seed, prev, v, hi, m, k;
int modes[6] = '{1, 2, 8, 9, 10, 11};
ccpo_channel dut (.clk_sys(clk_sys), .rst(rst), .ctrl(ctrl), .duty_compare_value(dcv),
    .compare_timebase(ctb), .period_timer(tmr), .conv_source_sel(conv_source_sel),
    .event_irq_en(event_irq_en), .sleep_mode(sleep_mode), .timebase_running(timebase_running),
    .pin_direction_bit(pin_direction_bit), .event_flag_clear(event_flag_clear), .status(status));
ccpo_load load (.pin_level(status.pin_level), .pin_oe(status.pin_oe), .pin_seen(pin_seen));
initial
begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
end
// stand-in period timer at 1:1 prescale; it stops in sleep
always @(negedge clk_sys)
    if (!sleep_mode)
    begin
        tb = (tb + 1) % (4 * (lim + 1));
        tmr = '{tb == 0, 2'(tb), 8'(tb >> 2)};
    end
task chk(input string n, input int e, input logic [15:0] s);
    tests_run++;
    if (s !== 16'(e))
    begin
        mismatches++;
        $display("BAD %s expected %0h seen %0h", n, e, s);
    end
endtask
task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task step;
    @(posedge clk_sys);
    #1;
endtask
task hit(input int mm);
    @(negedge clk_sys) ctrl.mode = 4'(mm);
    ctb = 0;
    event_flag_clear = 1;
    @(negedge clk_sys) event_flag_clear = 0;
    ctb = 5;
    step;
endtask
initial
begin
    {rst, conv_source_sel, pin_direction_bit} = 3'b111;
    {event_irq_en, sleep_mode, timebase_running, event_flag_clear} = 0;
    ctrl = '{1'b1, 1'b0, 4'h0};
    {dcv, ctb, tmr, tb, lim, seed, prev} = {16'h0005, 16'h0000, 11'h000, 32'd0, 32'd15, 32'd25, -32'd1};
    repeat (6) step;
    chk("status after reset", 0, 16'(status));
    @(negedge clk_sys);
    rst = 0;
    pin_direction_bit = 0;
    foreach (modes[i])
    begin
        m = modes[i];
        @(negedge clk_sys) ctrl.mode = 4'h0;
        hit(m);
        chk("pin", m != 9, status.pin_level);
        chk("flag and trigger", 3, {status.event_flag, status.conv_trigger});
        step;
        chk("timebase clear", m == 1 || m == 11, status.timebase_clear);
        chk("pin later", m == 2 || m == 8 || m == 1, status.pin_level);
    end
    hit(1);
    @(negedge clk_sys) dcv = 16'h0006;
    repeat (2) step;
    chk("cancelled clear", 0, status.timebase_clear);
    @(negedge clk_sys) {sleep_mode, dcv} = {1'b1, 16'h0005};
    hit(2);
    step;
    chk("sleep compare", 0, status.event_flag);
    @(negedge clk_sys) {timebase_running, event_irq_en} = 2'b11;
    hit(2);
    chk("wake", 3, {status.event_flag, status.wake_req});
    @(negedge clk_sys) {sleep_mode, pin_direction_bit, ctrl.mode} = {2'b01, 4'hC};
    for (int i = 0; i < 10; i++)
    begin
        k = 0;
        do
        begin
            @(negedge clk_sys);
            #1 k++;
        end while (!tmr.period_match && k < 2000);
        if (k >= 2000)
        begin
            mismatches++;
            summarize;
        end
        step;
        hi = pin_seen;
        @(negedge clk_sys);
        pin_direction_bit = 0;
        v = i == 0 ? 0 : i == 1 ? 4 * (lim + 1) + 3 : {$random(seed)} % (4 * lim + 8);
        d10 = 10'(v);
        ctrl.align_left = i % 2;
        dcv = i % 2 ? {d10, 6'h00} : {6'h00, d10};
        repeat (4 * (lim + 1) - 1)
        begin
            step;
            hi += pin_seen;
        end
        if (prev >= 0)
            chk("high cycles", prev < 4 * (lim + 1) ? prev : 4 * (lim + 1), 16'(hi));
        prev = v;
    end
    @(negedge clk_sys) sleep_mode = 1;
    step;
    hi = pin_seen;
    repeat (20) step;
    chk("frozen pin", hi, pin_seen);
    summarize;
end
endmodule
